// file: design/spm_power_ctrl.sv
// Suspend power-mode controller: mode entry, retention, clock/PLL gating, wake
`timescale 1ns/1ps
`include "spm_defines.svh"

// Functional notes
// - Normal mode keeps processor clock and all PLLs enabled.
// - Four low-power states exist: PHY-on, PHY-off suspend, standby, core down; only the two suspend states are implemented.
// - PHY-on suspend keeps superspeed PHY in U3, all other clocks stopped.
// - In both suspend states every I/O holds its pre-entry level.
// - Registers, buffer memory and RAM keep contents during suspend.
// - Wake by anything except reset pin does not reset program counter.
// - PHY-off suspend disables PHY, suspends USB, stops clocks and PLLs.
// - USB interface logic keeps its state in PHY-off suspend.
// - External processor may request PHY-on suspend via mailbox; honoured.
// - Wake on D+/D- change, identity pin change, receive resume, VBUS.
// - Wake when clear-to-send reaches the programmed polarity level.
// - Wake on parallel control line zero or hardware reset pin.
module spm_power_ctrl #(
    parameter int PLL_LOCK_TIMEOUT_CYC = `SPM_PLL_LOCK_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fw_req_valid,
    input wire spm_pkg::spm_req_t fw_req,
    input wire logic mbox_req_valid,
    input wire logic cts_wake_level,
    input wire logic hw_reset_req,
    input wire spm_pkg::spm_wake_in_t wake_in,
    input wire logic pll_locked,
    output spm_pkg::spm_ctrl_t ctrl,
    output logic [2:0] power_mode,
    output logic [7:0] wake_cause,
    output logic wake_done,
    output logic pll_lock_fail
);
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_PHY_ON,
        ST_PHY_OFF,
        ST_PLL_WAIT,
        ST_RESUME
    } spm_state_t;

    spm_state_t state_q, state_d;
    logic [31:0] lock_cnt_q;
    logic [7:0] wake_src;
    logic armed;
    logic any_wake;
    logic woke_by_reset;
    logic fw_phy_on, fw_phy_off;
    logic lock_timeout;
    logic pc_reset_q;

    // ==========================================================
    // Request and wake decode
    // ==========================================================
    assign fw_phy_on = fw_req_valid && fw_req == spm_pkg::SPM_REQ_PHY_ON;
    assign fw_phy_off = fw_req_valid && fw_req == spm_pkg::SPM_REQ_PHY_OFF;
    // Wake detector listens only while suspended
    assign armed = state_q == ST_PHY_ON || state_q == ST_PHY_OFF;
    assign any_wake = |wake_src;
    assign woke_by_reset = wake_src[`SPM_WAKE_RST];
    assign lock_timeout = lock_cnt_q >= PLL_LOCK_TIMEOUT_CYC - 1;

    spm_wake_detect u_wake (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .arm(armed),
        .wake_in(wake_in),
        .cts_wake_level(cts_wake_level),
        .hw_reset_req(hw_reset_req),
        .wake_src(wake_src)
    );

    // ==========================================================
    // Mode sequencer
    // ==========================================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL: begin
                // Mailbox wins: it can only ask for PHY-on suspend
                if (mbox_req_valid || fw_phy_on) begin
                    state_d = ST_PHY_ON;
                end else if (fw_phy_off) begin
                    state_d = ST_PHY_OFF;
                end
            end
            ST_PHY_ON: begin
                // No lock wait here; only PHY-off suspend waits for the PLL
                if (any_wake) begin
                    state_d = ST_RESUME;
                end
            end
            ST_PHY_OFF: begin
                if (any_wake) begin
                    state_d = ST_PLL_WAIT;
                end
            end
            ST_PLL_WAIT: begin
                // Timeout resumes anyway and flags the failure
                if (pll_locked || lock_timeout) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_d = ST_NORMAL;
            end
            default: begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // Cleared outside the wait so every wake gets a fresh timeout
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_q <= 32'h0000_0000;
        end else if (state_q == ST_PLL_WAIT) begin
            lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
        end else begin
            lock_cnt_q <= 32'h0000_0000;
        end
    end

    // Reset-pin wake is remembered until the resume cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reset_q <= 1'b0;
        end else if (armed && any_wake) begin
            pc_reset_q <= woke_by_reset;
        end else if (state_q == ST_NORMAL) begin
            pc_reset_q <= 1'b0;
        end
    end

    // ==========================================================
    // Power control outputs, all registered
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, pll_en: 1'b1, ss_phy_en: 1'b1,
                      ss_phy_u3: 1'b0, usb_suspend: 1'b0, io_hold: 1'b0,
                      ram_retain: 1'b0, cpu_run: 1'b1, cpu_pc_reset: 1'b0};
            power_mode <= `SPM_MODE_NORMAL;
        end else begin
            case (state_d)
                ST_PHY_ON: begin
                    // PHY stays up in U3 on its own clock; I/O and memories frozen
                    ctrl <= '{cpu_clk_en: 1'b0, sys_clk_en: 1'b0, pll_en: 1'b0,
                              ss_phy_en: 1'b1, ss_phy_u3: 1'b1, usb_suspend: 1'b1,
                              io_hold: 1'b1, ram_retain: 1'b1, cpu_run: 1'b0,
                              cpu_pc_reset: 1'b0};
                    power_mode <= `SPM_MODE_SUSP_PHY_ON;
                end
                ST_PHY_OFF: begin
                    ctrl <= '{cpu_clk_en: 1'b0, sys_clk_en: 1'b0, pll_en: 1'b0,
                              ss_phy_en: 1'b0, ss_phy_u3: 1'b0, usb_suspend: 1'b1,
                              io_hold: 1'b1, ram_retain: 1'b1, cpu_run: 1'b0,
                              cpu_pc_reset: 1'b0};
                    power_mode <= `SPM_MODE_SUSP_PHY_OFF;
                end
                ST_PLL_WAIT: begin
                    // PLL back on, clocks still gated until lock or timeout
                    ctrl <= '{cpu_clk_en: 1'b0, sys_clk_en: 1'b0, pll_en: 1'b1,
                              ss_phy_en: 1'b0, ss_phy_u3: 1'b0, usb_suspend: 1'b1,
                              io_hold: 1'b1, ram_retain: 1'b1, cpu_run: 1'b0,
                              cpu_pc_reset: 1'b0};
                    power_mode <= `SPM_MODE_SUSP_PHY_OFF;
                end
                ST_RESUME: begin
                    // Clocks back first; CPU and I/O are released one cycle later
                    ctrl <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, pll_en: 1'b1,
                              ss_phy_en: 1'b1, ss_phy_u3: 1'b0, usb_suspend: 1'b0,
                              io_hold: 1'b1, ram_retain: 1'b1, cpu_run: 1'b0,
                              cpu_pc_reset: pc_reset_q || woke_by_reset};
                    power_mode <= `SPM_MODE_NORMAL;
                end
                default: begin
                    ctrl <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, pll_en: 1'b1,
                              ss_phy_en: 1'b1, ss_phy_u3: 1'b0, usb_suspend: 1'b0,
                              io_hold: 1'b0, ram_retain: 1'b0, cpu_run: 1'b1,
                              cpu_pc_reset: 1'b0};
                    power_mode <= `SPM_MODE_NORMAL;
                end
            endcase
        end
    end

    // ==========================================================
    // Wake reporting
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cause <= 8'h00;
            wake_done <= 1'b0;
            pll_lock_fail <= 1'b0;
        end else begin
            // Sources of the last wake stay visible until the next wake
            if (armed && any_wake) begin
                wake_cause <= wake_src;
            end
            wake_done <= state_q == ST_RESUME;
            // A timeout in the same cycle as a request keeps the flag set
            if (state_q == ST_PLL_WAIT && !pll_locked && lock_timeout) begin
                pll_lock_fail <= 1'b1;
            end else if (fw_req_valid || mbox_req_valid) begin
                pll_lock_fail <= 1'b0;
            end
        end
    end
endmodule

// file: design/spm_defines.svh
// Timing counts and fixed encodings for the suspend power-mode controller
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_CLK_PERIOD_NS 25
`define SPM_PLL_LOCK_TIMEOUT_NS 100000
`define SPM_PLL_LOCK_TIMEOUT_CYC ((`SPM_PLL_LOCK_TIMEOUT_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS)
`define SPM_MODE_NORMAL 3'h0
`define SPM_MODE_SUSP_PHY_ON 3'h1
`define SPM_MODE_SUSP_PHY_OFF 3'h2
`define SPM_MODE_STANDBY 3'h3
`define SPM_MODE_CORE_PD 3'h4
`define SPM_WAKE_W 8
`define SPM_WAKE_DP 0
`define SPM_WAKE_DM 1
`define SPM_WAKE_ID 2
`define SPM_WAKE_SUPERSPEED_RECEIVE_PAIR 3
`define SPM_WAKE_VBUS 4
`define SPM_WAKE_CTS 5
`define SPM_WAKE_CTL0 6
`define SPM_WAKE_RST 7
`endif

// file: design/spm_pkg.sv
// Types shared by the suspend power-mode controller files
package spm_pkg;
    typedef enum logic [1:0] {
        SPM_REQ_NONE,
        SPM_REQ_PHY_ON,
        SPM_REQ_PHY_OFF
    } spm_req_t;

    typedef struct packed {
        logic usb_dp;
        logic usb_dm;
        logic cable_identity_pin;
        logic superspeed_receive_pair;
        logic vbus;
        logic uart_cts;
        logic parallel_port_control_line_zero;
    } spm_wake_in_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic sys_clk_en;
        logic pll_en;
        logic ss_phy_en;
        logic ss_phy_u3;
        logic usb_suspend;
        logic io_hold;
        logic ram_retain;
        logic cpu_run;
        logic cpu_pc_reset;
    } spm_ctrl_t;
endpackage

// file: design/spm_wake_detect.sv
// Wake-event detector: edge and level sources gathered into one vector
`timescale 1ns/1ps
module spm_wake_detect (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic arm,
    input wire spm_pkg::spm_wake_in_t wake_in,
    input wire logic cts_wake_level,
    input wire logic hw_reset_req,
    output logic [7:0] wake_src
);
    spm_pkg::spm_wake_in_t ref_q;
    logic [7:0] hit;

    // Baseline captured while not armed; D+, D- and identity pin changes against it are wake events
    assign hit[0] = wake_in.usb_dp != ref_q.usb_dp;
    assign hit[1] = wake_in.usb_dm != ref_q.usb_dm;
    assign hit[2] = wake_in.cable_identity_pin != ref_q.cable_identity_pin;
    assign hit[3] = wake_in.superspeed_receive_pair;
    assign hit[4] = wake_in.vbus;
    assign hit[5] = wake_in.uart_cts == cts_wake_level;
    assign hit[6] = wake_in.parallel_port_control_line_zero;
    assign hit[7] = hw_reset_req;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= '0;
        end else if (!arm) begin
            ref_q <= wake_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_src <= 8'h00;
        end else begin
            wake_src <= arm ? hit : 8'h00;
        end
    end
endmodule

// file: tb/spm_pll_model.sv
// Behavioural PLL facing the power-mode controller
`timescale 1ns/1ps
module spm_pll_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pll_en,
    input wire logic [7:0] lock_delay,
    output logic pll_locked
);
    int cnt_q;
    // Lock drops at once when disabled; a delay of zero never locks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 0;
        end else if (!pll_en) begin
            cnt_q <= 0;
        end else if (cnt_q < 1000) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign pll_locked = pll_en && lock_delay != 8'h00 && cnt_q >= int'(lock_delay);
endmodule

// file: tb/spm_power_ctrl_props.sv
// Port-level checks for the suspend power-mode controller
`timescale 1ns/1ps
module spm_power_ctrl_props #(
    parameter int PLL_LOCK_TIMEOUT_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fw_req_valid,
    input wire spm_pkg::spm_req_t fw_req,
    input wire logic mbox_req_valid,
    input wire logic cts_wake_level,
    input wire logic hw_reset_req,
    input wire spm_pkg::spm_wake_in_t wake_in,
    input wire logic pll_locked,
    input wire spm_pkg::spm_ctrl_t ctrl,
    input wire logic [2:0] power_mode,
    input wire logic [7:0] wake_cause,
    input wire logic wake_done,
    input wire logic pll_lock_fail
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire idle = power_mode == 3'h0 && ctrl.cpu_run && !wake_done;
    wire relock = power_mode == 3'h2 && ctrl.pll_en && !ctrl.sys_clk_en;
    int relock_cnt;
    // Cycles spent waiting for the PLL after a PHY-off wake
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            relock_cnt <= 0;
        end else if (relock) begin
            relock_cnt <= relock_cnt + 1;
        end else begin
            relock_cnt <= 0;
        end
    end
    sequence vbus_resp_s;
        ##1 wake_cause[4] ##1 wake_done;
    endsequence
    chk_normal_clk_on: assert property (idle |-> ctrl.cpu_clk_en && ctrl.pll_en)
        else $error("clock or pll off in normal mode");
    chk_fw_off_entry: assert property (idle && fw_req_valid && !mbox_req_valid &&
        fw_req == spm_pkg::SPM_REQ_PHY_OFF |=> power_mode == 3'h2 && ctrl.io_hold &&
        ctrl.ram_retain && ctrl.usb_suspend && !ctrl.pll_en && !ctrl.ss_phy_en)
        else $error("phy-off entry wrong");
    chk_mbox_entry: assert property (idle && mbox_req_valid |=> power_mode == 3'h1 &&
        ctrl.ss_phy_en && ctrl.ss_phy_u3 && !ctrl.cpu_clk_en && !ctrl.sys_clk_en)
        else $error("mailbox entry wrong");
    chk_hold_in_susp: assert property (power_mode inside {3'h1, 3'h2} && !wake_done
        |-> ctrl.io_hold)
        else $error("io hold lost in suspend");
    chk_pc_kept: assert property (ctrl.cpu_pc_reset |-> wake_cause[7])
        else $error("pc reset without reset pin");
    chk_vbus_wake: assert property ($rose(wake_in.vbus) && power_mode == 3'h1 &&
        $past(power_mode) == 3'h1 |-> ##1 vbus_resp_s)
        else $error("vbus wake timing wrong");
    chk_relock_wait: assert property (power_mode == 3'h2 && ctrl.pll_en &&
        !ctrl.sys_clk_en |-> !ctrl.cpu_run ##[1:12] ctrl.sys_clk_en)
        else $error("pll wait wrong");
    chk_done_pulse: assert property (wake_done |=> !wake_done && power_mode == 3'h0 &&
        ctrl.cpu_run)
        else $error("wake completion wrong");
    chk_relock_bound: assert property (relock |-> relock_cnt < PLL_LOCK_TIMEOUT_CYC)
        else $error("pll wait outlasts timeout");
endmodule
bind spm_power_ctrl spm_power_ctrl_props #(.PLL_LOCK_TIMEOUT_CYC(PLL_LOCK_TIMEOUT_CYC)) u_props (
    .sys_clk, .rst_n, .fw_req_valid, .fw_req, .mbox_req_valid, .cts_wake_level,
    .hw_reset_req, .wake_in, .pll_locked, .ctrl, .power_mode, .wake_cause, .wake_done,
    .pll_lock_fail);

// file: tb/spm_power_ctrl_tb.sv
// Self-checking bench for the suspend power-mode controller
`timescale 1ns/1ps
module spm_power_ctrl_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fw_req_valid = 1'b0;
    spm_pkg::spm_req_t fw_req = spm_pkg::SPM_REQ_NONE;
    logic mbox_req_valid = 1'b0;
    logic cts_wake_level = 1'b1;
    logic hw_reset_req = 1'b0;
    spm_pkg::spm_wake_in_t wake_in = '0;
    logic pll_locked;
    logic [7:0] lock_delay = 8'h03;
    spm_pkg::spm_ctrl_t ctrl;
    logic [2:0] power_mode;
    logic [7:0] wake_cause;
    logic wake_done;
    logic pll_lock_fail;
    logic pc_seen;
    int error_cnt = 0;
    int tests_run = 0;
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    spm_power_ctrl #(.PLL_LOCK_TIMEOUT_CYC(8)) dut (.sys_clk, .rst_n, .fw_req_valid, .fw_req,
        .mbox_req_valid, .cts_wake_level, .hw_reset_req, .wake_in, .pll_locked, .ctrl,
        .power_mode, .wake_cause, .wake_done, .pll_lock_fail);
    spm_pll_model pll (.sys_clk, .rst_n, .pll_en(ctrl.pll_en), .lock_delay, .pll_locked);
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic enter(input logic mb, input spm_pkg::spm_req_t r);
        @(negedge sys_clk);
        mbox_req_valid = mb;
        fw_req_valid = !mb;
        fw_req = r;
        @(negedge sys_clk);
        mbox_req_valid = 1'b0;
        fw_req_valid = 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        pc_seen = 1'b0;
        while (wake_done !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            if (ctrl.cpu_pc_reset === 1'b1) pc_seen = 1'b1;
            n++;
        end
        check(wake_done === 1'b1, "no wake completion");
        wake_in = '0;
        hw_reset_req = 1'b0;
    endtask
    task automatic t_phy_off(input logic [7:0] dly, input logic fail);
        lock_delay = dly;
        enter(1'b0, spm_pkg::SPM_REQ_PHY_OFF);
        check(power_mode === 3'h2 && ctrl === 10'h01C, "phy-off outputs");
        enter(1'b1, spm_pkg::SPM_REQ_NONE);
        check(power_mode === 3'h2, "request in suspend taken");
        wake_in.usb_dm = 1'b1;
        wait_done();
        check(wake_cause === 8'h02 && pll_lock_fail === fail, "phy-off wake");
        check(pc_seen === 1'b0, "pc reset on pin-less wake");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 8; i++) begin
            enter(i[0], i[0] ? spm_pkg::SPM_REQ_NONE : spm_pkg::SPM_REQ_PHY_ON);
            check(power_mode === 3'h1 && ctrl.ss_phy_u3 === 1'b1, "phy-on entry");
            check(ctrl.cpu_clk_en === 1'b0 && ctrl.io_hold === 1'b1, "phy-on hold");
            repeat (3) @(negedge sys_clk);
            if (i == 7) hw_reset_req = 1'b1;
            else wake_in[6 - i] = 1'b1;
            wait_done();
            check(wake_cause === (8'h01 << i), "wake source");
            check(pc_seen === (i == 7), "pc reset choice");
        end
    endtask
    task automatic t_cts_low();
        wake_in.uart_cts = 1'b1;
        cts_wake_level = 1'b0;
        enter(1'b0, spm_pkg::SPM_REQ_PHY_OFF);
        repeat (4) @(negedge sys_clk);
        check(power_mode === 3'h2, "woke on wrong cts level");
        wake_in.uart_cts = 1'b0;
        wait_done();
        check(wake_cause === 8'h20, "cts wake cause");
        // Back to high polarity so a low idle CTS cannot wake later suspends
        cts_wake_level = 1'b1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check(ctrl === 10'h3C2 && power_mode === 3'h0 && wake_done === 1'b0, "reset");
        t_phy_off(8'h03, 1'b0);
        t_sources();
        t_cts_low();
        t_phy_off(8'h00, 1'b1);
        complete_run();
    end
endmodule
